//--- inc/swire_host_defines.vh
`ifndef SWIRE_HOST_DEFINES_VH
`define SWIRE_HOST_DEFINES_VH
// -----------------------------------------------------------------------------
// Clock and link timing (microseconds and derived cycle counts at 100 MHz)
// -----------------------------------------------------------------------------
`define CLK_MHZ              100
`define RESET_LOW_US         480
`define RESET_HIGH_US        480
`define PRESENCE_SAMPLE_US   70
`define SLOT_US              70
`define LOW1_US              6
`define LOW0_US              65
`define SAMPLE_US            13
`define RECOVERY_US          2
`define PROG_PULSE_US        480
`define PROG_DELAY_US        5
`define US_TO_CYC(us)        ((us) * `CLK_MHZ)
`define CNT_W                16
// -----------------------------------------------------------------------------
// Protocol constants
// -----------------------------------------------------------------------------
`define CRC_POLY             16'hA001
`define CRC_INIT             16'h0000
`define HIGH_ADDR_MASK       8'h07
`define HIGH_ADDR_FORCE      8'hF8
`define FIFO_WIDTH           8
`define FIFO_DEPTH           32
`define FIFO_AW              5
`endif

//--- src/byte_fifo.v
`timescale 1ns/1ps
`default_nettype none
module byte_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clock_i,
  input  wire             arst_n_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam [AW:0] FULL_COUNT = DEPTH;

  reg [WIDTH-1:0] mem_r [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_r;
  reg [AW-1:0]    rd_ptr_r;
  reg [AW:0]      count_r;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count_r != FULL_COUNT);
  assign out_valid_o = (count_r != {(AW+1){1'b0}});
  assign out_data_o  = mem_r[rd_ptr_r];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge clock_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end

  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push & ~pop) begin
        count_r <= count_r + {{AW{1'b0}}, 1'b1};
      end else if (pop & ~push) begin
        count_r <= count_r - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // byte_fifo
`default_nettype wire

//--- src/swire_write_host.v
// Function
// - CRC mismatch never stops device; master decides to continue or abort
// - master waits reset-high interval of 480 us after reset
// - master samples read data late but inside the 15 us window
// - under low pull-up voltage master may set top address bits
// - after CRC confirmed master applies 480 us programming pulse
`timescale 1ns/1ps
`default_nettype none
`include "swire_host_defines.vh"
module swire_write_host #(
  parameter CYC_PER_US = `CLK_MHZ
) (
  // Clock and reset
  input  wire        clock_i,
  input  wire        arst_n_i,
  // Command
  input  wire        start_i,
  input  wire [7:0]  cmd_i,
  input  wire [15:0] addr_i,
  input  wire        low_pullup_supply_level_i,
  input  wire        abort_on_error_i,
  output wire        busy_o,
  output reg         done_o,
  output reg         presence_err_o,
  output reg         crc_err_o,
  // Data stream
  input  wire        data_valid_i,
  output wire        data_ready_o,
  input  wire [7:0]  data_i,
  // Single-wire line
  input  wire        line_i,
  output wire        line_o,
  output wire        line_oe_o,
  output reg         prog_en_o
);
  localparam [7:0] S_IDLE  = 8'h01;
  localparam [7:0] S_RST   = 8'h02;
  localparam [7:0] S_TX    = 8'h04;
  localparam [7:0] S_RX    = 8'h08;
  localparam [7:0] S_CHECK = 8'h10;
  localparam [7:0] S_PROG  = 8'h20;
  localparam [7:0] S_REC   = 8'h40;
  localparam [7:0] S_DONE  = 8'h80;

  // Reset high is counted from the release, so every count fits the counter
  localparam [15:0] RST_LOW_CYC  = `RESET_LOW_US * CYC_PER_US;
  localparam [15:0] RST_END_CYC  = `RESET_HIGH_US * CYC_PER_US;
  localparam [15:0] PRES_CYC     = `PRESENCE_SAMPLE_US * CYC_PER_US;
  localparam [15:0] SLOT_CYC     = (`SLOT_US + `RECOVERY_US) * CYC_PER_US;
  localparam [15:0] LOW1_CYC     = `LOW1_US * CYC_PER_US;
  localparam [15:0] LOW0_CYC     = `LOW0_US * CYC_PER_US;
  localparam [15:0] SAMPLE_CYC   = `SAMPLE_US * CYC_PER_US;
  localparam [15:0] PROG_CYC     = `PROG_PULSE_US * CYC_PER_US;
  localparam [15:0] PDLY_CYC     = `PROG_DELAY_US * CYC_PER_US;

  // ---------------------------------------------------------------------------
  // CRC helper
  // ---------------------------------------------------------------------------
  function [15:0] crc_bit;
    input [15:0] crc;
    input        b;
    begin
      crc_bit = (crc[0] ^ b) ? ((crc >> 1) ^ `CRC_POLY) : (crc >> 1);
    end
  endfunction

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  reg [7:0]       state_r;
  reg [`CNT_W-1:0] cnt_r;
  reg [7:0]       sh_r;
  reg [3:0]       bit_r;
  reg [2:0]       phase_r;
  reg             first_r;
  reg [15:0]      addr_r;
  reg [15:0]      crc_r;
  reg [15:0]      rx_r;
  reg             drive_low_r;
  reg             seen_low_r;
  reg             take_r;

  wire       fifo_valid;
  wire [7:0] fifo_data;
  wire [7:0] high_sent = low_pullup_supply_level_i ? (addr_i[15:8] | `HIGH_ADDR_FORCE) : addr_i[15:8];
  wire [7:0] high_crc  = addr_i[15:8] & `HIGH_ADDR_MASK;
  wire [7:0] high_keep = `HIGH_ADDR_MASK;
  // Device clears the forced high-address bits before its CRC, so the host does too
  wire       crc_in    = (phase_r == 3'h2) ? (sh_r[0] & high_keep[bit_r[2:0]]) : sh_r[0];

  byte_fifo #(
    .WIDTH (`FIFO_WIDTH),
    .DEPTH (`FIFO_DEPTH),
    .AW    (`FIFO_AW)
  ) byte_fifo_inst (
    .clock_i     (clock_i),
    .arst_n_i    (arst_n_i),
    .in_valid_i  (data_valid_i),
    .in_ready_o  (data_ready_o),
    .in_data_i   (data_i),
    .out_valid_o (fifo_valid),
    .out_ready_i (take_r),
    .out_data_o  (fifo_data)
  );

  assign busy_o    = (state_r != S_IDLE);
  assign line_o    = 1'b0;
  assign line_oe_o = drive_low_r;

  // Phases of one write pass: 0 cmd, 1 addr low, 2 addr high, 3 data, then CRC read
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_r        <= S_IDLE;
      cnt_r          <= 16'h0000;
      sh_r           <= 8'h00;
      bit_r          <= 4'h0;
      phase_r        <= 3'h0;
      first_r        <= 1'b0;
      addr_r         <= 16'h0000;
      crc_r          <= `CRC_INIT;
      rx_r           <= 16'h0000;
      drive_low_r    <= 1'b0;
      seen_low_r     <= 1'b0;
      take_r         <= 1'b0;
      done_o         <= 1'b0;
      presence_err_o <= 1'b0;
      crc_err_o      <= 1'b0;
      prog_en_o      <= 1'b0;
    end else begin
      done_o <= 1'b0;
      take_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          drive_low_r <= 1'b0;
          if (start_i) begin
            presence_err_o <= 1'b0;
            crc_err_o      <= 1'b0;
            first_r        <= 1'b1;
            addr_r         <= {high_crc, addr_i[7:0]};
            crc_r          <= `CRC_INIT;
            seen_low_r     <= 1'b0;
            cnt_r          <= 16'h0000;
            drive_low_r    <= 1'b1;
            state_r        <= S_RST;
          end
        end
        S_RST: begin
          cnt_r <= cnt_r + 16'h0001;
          // Low phase and reset-high phase each count from zero
          if (drive_low_r && cnt_r == RST_LOW_CYC) begin
            drive_low_r <= 1'b0;
            cnt_r       <= 16'h0000;
          end
          if (!drive_low_r && cnt_r > PRES_CYC && cnt_r < RST_END_CYC && !line_i) begin
            seen_low_r <= 1'b1;
          end
          if (!drive_low_r && cnt_r == RST_END_CYC) begin
            if (!seen_low_r) begin
              presence_err_o <= 1'b1;
              state_r        <= S_DONE;
            end else begin
              phase_r <= 3'h0;
              sh_r    <= cmd_i;
              bit_r   <= 4'h0;
              cnt_r   <= 16'h0000;
              state_r <= S_TX;
            end
          end
        end
        S_TX: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'h0000) begin
            if (phase_r == 3'h3 && bit_r == 4'h0 && !fifo_valid) begin
              cnt_r <= 16'h0000;               // Wait for data
            end else begin
              if (phase_r == 3'h3 && bit_r == 4'h0) begin
                sh_r <= fifo_data;
                take_r <= 1'b1;
                crc_r  <= crc_bit(crc_r, fifo_data[0]);
              end else begin
                crc_r <= crc_bit(crc_r, crc_in);
              end
              drive_low_r <= 1'b1;
            end
          end
          if (cnt_r == LOW1_CYC && sh_r[0]) drive_low_r <= 1'b0;
          if (cnt_r == LOW0_CYC) drive_low_r <= 1'b0;
          if (cnt_r == SLOT_CYC) begin
            cnt_r <= 16'h0000;
            sh_r  <= {1'b0, sh_r[7:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h7) begin
              bit_r   <= 4'h0;
              phase_r <= phase_r + 3'h1;
              if (phase_r == 3'h0) sh_r <= addr_i[7:0];
              if (phase_r == 3'h1) sh_r <= high_sent;
              if (phase_r == 3'h3) state_r <= S_RX;
            end
          end
        end
        S_RX: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'h0000) drive_low_r <= 1'b1;
          if (cnt_r == LOW1_CYC) drive_low_r <= 1'b0;
          if (cnt_r == SAMPLE_CYC) rx_r <= {line_i, rx_r[15:1]};
          if (cnt_r == SLOT_CYC) begin
            cnt_r <= 16'h0000;
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'hF) begin
              bit_r   <= 4'h0;
              state_r <= S_CHECK;
            end
          end
        end
        S_CHECK: begin
          cnt_r <= 16'h0000;
          if (~rx_r != crc_r) begin
            crc_err_o <= 1'b1;
            state_r   <= abort_on_error_i ? S_DONE : S_REC;
          end else begin
            state_r <= S_PROG;
          end
        end
        S_PROG: begin
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == PDLY_CYC) prog_en_o <= 1'b1;
          if (cnt_r == PDLY_CYC + PROG_CYC) begin
            prog_en_o <= 1'b0;
            cnt_r     <= 16'h0000;
            state_r   <= S_REC;
          end
        end
        S_REC: begin
          // Device returns programmed byte; host skips it and reloads CRC state
          cnt_r <= cnt_r + 16'h0001;
          if (cnt_r == 16'h0000) drive_low_r <= 1'b1;
          if (cnt_r == LOW1_CYC) drive_low_r <= 1'b0;
          if (cnt_r == SLOT_CYC) begin
            cnt_r <= 16'h0000;
            bit_r <= bit_r + 4'h1;
            if (bit_r == 4'h7) begin
              bit_r   <= 4'h0;
              first_r <= 1'b0;
              addr_r  <= addr_r + 16'h0001;
              crc_r   <= addr_r + 16'h0001;
              phase_r <= 3'h3;
              if (fifo_valid) state_r <= S_TX;
              else state_r <= S_DONE;
            end
          end
        end
        S_DONE: begin
          drive_low_r <= 1'b0;
          prog_en_o   <= 1'b0;
          done_o      <= 1'b1;
          state_r     <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end
endmodule // swire_write_host
`default_nettype wire

//--- tb/swire_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "swire_host_defines.vh"
module swire_dev_model #(
  parameter int CYC_PER_US = 100
) (
  // Bench clock, wire and programming level
  input  wire logic clock_i,
  input  wire logic line_i,
  input  wire logic prog_en_i,
  output var  logic pull_o,
  // Faults on command
  input  wire logic mute_i,
  input  wire logic bad_crc_i
);
  // Nanoseconds per link microsecond: CYC_PER_US clocks of 10 ns
  localparam int US = CYC_PER_US * 10;
  logic [7:0]  mem [0:2047];
  logic [7:0]  cmd, lo, raw_hi, hi, d;
  logic [10:0] addr;
  logic [15:0] crc;
  logic [15:0] low_cnt = 16'h0000;
  logic        rst_seen = 1'b0;
  time         t0;
  function automatic [15:0] crc8(input [15:0] c, input [7:0] b);
    crc8 = c;
    for (int k = 0; k < 8; k++) crc8 = (crc8[0] ^ b[k]) ? (crc8 >> 1) ^ `CRC_POLY : crc8 >> 1;
  endfunction
  task rx(output [7:0] b);
    for (int k = 0; k < 8; k++) begin
      @(negedge line_i);
      #(15 * US) b[k] = line_i;
    end
  endtask
  // A zero is held for the valid window only, then released
  task tx(input [7:0] b);
    for (int k = 0; k < 8; k++) begin
      @(negedge line_i);
      #(1 * US) pull_o = !b[k];
      #(14 * US) pull_o = 1'b0;
    end
  endtask
  initial for (int j = 0; j < 2048; j++) mem[j] = 8'hFF;
  always @(posedge clock_i) begin
    low_cnt <= (line_i !== 1'b0) ? 16'h0000 : low_cnt + 16'h0001;
    if (int'(low_cnt) == 470 * CYC_PER_US) begin
      rst_seen <= 1'b1;
      disable run;
    end
  end
  initial forever begin : run
    pull_o = 1'b0;
    wait (rst_seen && line_i);
    rst_seen = 1'b0;
    #(30 * US) pull_o = !mute_i;
    #(120 * US) pull_o = 1'b0;
    rx(cmd);
    rx(lo);
    rx(raw_hi);
    hi = raw_hi & `HIGH_ADDR_MASK;
    addr = {hi[2:0], lo};
    crc = crc8(crc8(crc8(16'h0000, cmd), lo), hi);
    forever begin
      rx(d);
      crc = crc8(crc, d);
      tx(~crc[7:0] ^ {7'h00, bad_crc_i});
      tx(~crc[15:8]);
      // Programming is never gated by the CRC outcome
      @(posedge prog_en_i);
      t0 = $time;
      @(negedge prog_en_i);
      if ($time - t0 >= 480 * US) mem[addr] = d;
      tx(mem[addr]);
      addr = addr + 11'h001;
      crc = {5'h00, addr};
    end
  end
endmodule // swire_dev_model
`default_nettype wire

//--- tb/swire_write_host_chk.sv
`timescale 1ns/1ps
`default_nettype none
module swire_write_host_chk #(
  parameter int CYC_PER_US = 100
) (
  // Watched ports
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic start_i,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic line_oe_o,
  input wire logic prog_en_o
);
  logic [15:0] oe_cnt, gap_cnt, pp_cnt;
  logic        was_rst;
  localparam int T1   = CYC_PER_US;
  localparam int T5   = 5 * CYC_PER_US;
  localparam int T15  = 15 * CYC_PER_US;
  localparam int T60  = 60 * CYC_PER_US;
  localparam int T120 = 120 * CYC_PER_US;
  localparam int T480 = 480 * CYC_PER_US;
  default clocking @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  always @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      oe_cnt  <= 16'h0000;
      gap_cnt <= 16'hFFFF;
      pp_cnt  <= 16'h0000;
      was_rst <= 1'b0;
    end else begin
      oe_cnt  <= line_oe_o ? oe_cnt + {15'h0000, ~&oe_cnt} : 16'h0000;
      gap_cnt <= line_oe_o ? 16'h0000 : gap_cnt + {15'h0000, ~&gap_cnt};
      pp_cnt  <= prog_en_o ? pp_cnt + {15'h0000, ~&pp_cnt} : 16'h0000;
      if (line_oe_o) was_rst <= 1'b0;
      else if (oe_cnt >= T480) was_rst <= 1'b1;
    end
  end
  sequence s_pull_end; $fell(line_oe_o); endsequence
  sequence s_pull_start; $rose(line_oe_o); endsequence
  sequence s_prog_start; $rose(prog_en_o); endsequence
  a_pull_len: assert property (s_pull_end |-> (oe_cnt >= T1 && oe_cnt <= T15) ||
    (oe_cnt >= T60 && oe_cnt <= T120) || oe_cnt >= T480) else $error("pull-low length off");
  a_slot_recovery: assert property (s_pull_start |-> gap_cnt >= T1) else $error("recovery short");
  a_reset_gap: assert property (s_pull_start ##0 was_rst |-> gap_cnt >= T480)
    else $error("traffic too soon after reset");
  a_prog_no_pull: assert property (prog_en_o |-> !line_oe_o) else $error("pull during program");
  a_prog_width: assert property ($fell(prog_en_o) |-> pp_cnt >= T480) else $error("program short");
  a_prog_delay: assert property (s_prog_start |-> gap_cnt >= T5) else $error("program too early");
  a_done_single: assert property (done_o |=> !done_o) else $error("done longer than one cycle");
  a_start_taken: assert property (start_i && !busy_o |-> ##[1:2] line_oe_o) else $error("start not taken");
endmodule // swire_write_host_chk
bind swire_write_host swire_write_host_chk #(.CYC_PER_US(CYC_PER_US)) swire_write_host_chk_inst (
  .clock_i, .arst_n_i, .start_i, .busy_o, .done_o, .line_oe_o, .prog_en_o);
`default_nettype wire

//--- tb/swire_write_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
module swire_write_host_bench;
  logic        clock_i, arst_n_i, start_i, low_pullup_supply_level_i, abort_on_error_i, data_valid_i, mute, bad_crc;
  logic [7:0]  cmd_i, data_i, seed;
  logic [7:0]  exp_q [0:31];
  logic [15:0] addr_i;
  wire         busy_o, done_o, presence_err_o, crc_err_o, data_ready_o, line_o, line_oe_o, prog_en_o, dev_pull;
  wire         line_i = !((line_oe_o && !line_o) || dev_pull);
  integer      err_total = 0, total_checks = 0, cyc = 0, i;
  // Link time compressed to one clock per microsecond to keep the run short
  localparam int CYC_PER_US = 1;
  swire_write_host #(.CYC_PER_US(CYC_PER_US)) swire_write_host_inst (.clock_i, .arst_n_i, .start_i, .cmd_i,
    .addr_i, .low_pullup_supply_level_i, .abort_on_error_i, .busy_o, .done_o, .presence_err_o, .crc_err_o, .data_valid_i,
    .data_ready_o, .data_i, .line_i, .line_o, .line_oe_o, .prog_en_o);
  swire_dev_model #(.CYC_PER_US(CYC_PER_US)) dev_inst (.clock_i, .line_i, .prog_en_i(prog_en_o),
    .pull_o(dev_pull), .mute_i(mute), .bad_crc_i(bad_crc));
  function automatic [7:0] lfsr(input [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  function automatic [10:0] slot_addr(input [15:0] a, input integer n);
    slot_addr = a[10:0] + n[10:0];
  endfunction
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task fill(input integer n);
    for (i = 0; i < n; i++) begin
      seed = lfsr(seed);
      exp_q[i] = seed;
      data_i = seed;
      data_valid_i = 1'b1;
      @(negedge clock_i);
    end
    data_valid_i = 1'b0;
  endtask
  task run_seq(input [15:0] a);
    @(negedge clock_i);
    seed = lfsr(seed);
    cmd_i = seed;
    addr_i = a;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    do @(negedge clock_i); while (done_o !== 1'b1);
  endtask
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 120000) begin
      err_total = err_total + 1;
      results();
    end
  end
  initial begin
    {arst_n_i, start_i, abort_on_error_i, data_valid_i, mute, bad_crc} = 6'h00;
    {cmd_i, data_i, addr_i} = 32'h0000_0000;
    low_pullup_supply_level_i = 1'b1;
    seed = 8'h36;
    repeat (3) @(negedge clock_i);
    arst_n_i = 1'b1;
    // Full buffer, run crossing a 256-byte boundary, low pull-up
    fill(32);
    chk(data_ready_o, 1'b0);
    run_seq({5'h00, 1'b0, seed[1:0], 8'hF0});
    chk(data_ready_o, 1'b1);
    chk(crc_err_o, 1'b0);
    chk(presence_err_o, 1'b0);
    chk(dev_inst.raw_hi[7:3], 5'h1F);
    for (i = 0; i < 32; i++) chk(dev_inst.mem[slot_addr(addr_i, i)], exp_q[i]);
    $display("test buffered write ended");
    // Corrupted CRC with abort: nothing programmed
    low_pullup_supply_level_i = 1'b0;
    abort_on_error_i = 1'b1;
    bad_crc = 1'b1;
    fill(1);
    run_seq(16'h0123);
    chk(crc_err_o, 1'b1);
    chk(dev_inst.mem[11'h123], 8'hFF);
    chk(dev_inst.raw_hi, 8'h01);
    $display("test crc abort ended");
    // Silent device, with a start while busy
    bad_crc = 1'b0;
    mute = 1'b1;
    fork
      run_seq(16'h0200);
      begin
        repeat (9) @(negedge clock_i);
        start_i = 1'b1;
        @(negedge clock_i);
        start_i = 1'b0;
      end
    join
    chk(presence_err_o, 1'b1);
    chk(crc_err_o, 1'b0);
    @(negedge clock_i);
    chk(busy_o, 1'b0);
    $display("test no presence ended");
    results();
  end
endmodule // swire_write_host_bench
`default_nettype wire
